/* File: rtl/monitor_status_reset_control.sv */
/*
 Status, interrupt, reset-pin and board-test control of a serial-bus
 hardware monitor. Assumes a serial-bus engine issuing pointer writes,
 register writes and reads as one-cycle pulses, and a monitoring loop that
 reports flags and the end of each pass.
*/
`timescale 1ns/1ps
`default_nettype none
module monitor_status_reset_control
    import msrc_pkg::*;
#(
    parameter int TREE_N      = 16,          // Pins in the test tree
    parameter int PULSE_LEN   = PULSE_CYC,   // Reset and intrusion pulse cycles
    parameter int REFRESH_LEN = REFRESH_CYC  // Least refresh after clear
) (
    input  wire logic                core_clk,            // 20 MHz clock
    input  wire logic                rst,                 // Power-on reset
    input  wire msrc_pkg::host_req_t host_req,            // Bus engine request
    output logic [7:0]               rd_data,             // Read answer
    input  wire msrc_pkg::events_t   loop_events,         // New loop flags
    input  wire logic                loop_pass_done,      // Loop pass end
    output logic                     monitor_run,         // Loop may scan
    output logic                     int_n,               // Interrupt, low
    input  wire logic                reset_pin_in,        // Reset pin level
    output logic                     reset_pin_out,       // Reset pin drive
    output logic                     reset_pin_oe_n,      // Low while driving
    output logic                     intrusion_clear_bit, // Intrusion pulse, low
    output logic                     analog_data_reset,   // Clear analog data
    input  wire logic                analog_out_tree_in,  // Test-mode request
    input  wire logic [TREE_N-1:0]   tree_pins,           // Tree pins
    output logic                     addr_sel_low_tree_out, // Tree result
    output logic                     tree_mode            // Test mode active
);
    import msrc_pkg::*;

    localparam logic [TREE_N+1:0] SYNC_RST = {1'b1, 1'b0, {TREE_N{1'b1}}};

    state_t            s_reg;
    state_t            s_next;
    logic [TREE_N+1:0] sync_q;
    logic              pin_level;
    logic              tree_req;
    logic [TREE_N-1:0] tree_q;
    logic              rst_busy, rst_done;
    logic              ci_busy, ci_done;
    logic              ref_busy;
    logic              rd_st;
    logic              pin_reset;
    logic              merge;

    // Reset pin, test request and tree pins come from the board
    pin_sync #(.W(TREE_N + 2), .RST_VAL(SYNC_RST)) u_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin      ({reset_pin_in, analog_out_tree_in, tree_pins}),
        .q        (sync_q)
    );
    assign pin_level = sync_q[TREE_N+1];
    assign tree_req  = sync_q[TREE_N];
    assign tree_q    = sync_q[TREE_N-1:0];

    // Reset pulse length counted on the core clock
    pulse_timer #(.CYC(PULSE_LEN)) u_rst_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (pin_reset),
        .start    (s_reg.cfg[CFG_RST_PULSE] && s_reg.msk2[MASK2_RST_EN] && !rst_done),
        .busy     (rst_busy),
        .done     (rst_done)
    );

    pulse_timer #(.CYC(PULSE_LEN)) u_ci_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (pin_reset),
        .start    (s_reg.cfg[CFG_CI_PULSE] && !ci_done),
        .busy     (ci_busy),
        .done     (ci_done)
    );

    // Refresh guard after a clearing read
    pulse_timer #(.CYC(REFRESH_LEN)) u_ref_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .clear    (pin_reset),
        .start    (rd_st),
        .busy     (ref_busy),
        .done     ()
    );

    assign rd_st = host_req.rd && (s_reg.ptr == ADDR_STATUS1 || s_reg.ptr == ADDR_STATUS2);
    // Blanking hides our own low drive still travelling the synchroniser
    assign pin_reset = s_reg.msk2[MASK2_RST_EN] && s_reg.rst_oe_n && !rst_busy
                       && (s_reg.blank == BLANK_ZERO) && !pin_level;
    assign merge = loop_pass_done && !ref_busy && !s_reg.cfg[CFG_HOLD];

    // Next-state logic for registers, status flags and pins
    always_comb begin
        logic init;
        logic [7:0] st1_cur;
        logic [7:0] st2_cur;
        init    = 1'b0;
        st1_cur = BYTE_ZERO;
        st2_cur = BYTE_ZERO;
        s_next = s_reg;
        s_next.dac_rst = 1'b0;
        // Clear-on-read; a merge in the same cycle wins
        if (host_req.rd) begin
            case (s_reg.ptr)
                ADDR_CONFIG:    s_next.rd_data = s_reg.cfg;
                ADDR_STATUS1: begin
                    s_next.rd_data = s_reg.st1;
                    s_next.st1     = BYTE_ZERO;
                end
                ADDR_STATUS2: begin
                    s_next.rd_data = s_reg.st2;
                    s_next.st2     = BYTE_ZERO;
                end
                ADDR_MASK1:     s_next.rd_data = s_reg.msk1;
                ADDR_MASK2:     s_next.rd_data = s_reg.msk2;
                ADDR_INTRUSION: s_next.rd_data = {s_reg.cfg[CFG_CI_PULSE], s_reg.intr_low};
                default:        s_next.rd_data = BYTE_ZERO;
            endcase
        end
        // Loop flags gather in pending until a pass may be merged
        if (merge) begin
            s_next.st1   = s_next.st1 | s_reg.pend1;
            s_next.st2   = s_next.st2 | s_reg.pend2;
            s_next.pend1 = loop_events.st1;
            s_next.pend2 = loop_events.st2;
        end else begin
            s_next.pend1 = s_reg.pend1 | loop_events.st1;
            s_next.pend2 = s_reg.pend2 | loop_events.st2;
        end
        if (host_req.ptr_wr) begin
            s_next.ptr = host_req.data;
        end
        if (host_req.wr) begin
            case (s_reg.ptr)
                ADDR_CONFIG: begin
                    s_next.cfg        = host_req.data;
                    s_next.tree_armed = 1'b0;
                    init              = host_req.data[CFG_INIT];
                end
                ADDR_MASK1:     s_next.msk1 = host_req.data;
                ADDR_MASK2:     s_next.msk2 = host_req.data;
                ADDR_INTRUSION: begin
                    s_next.intr_low = host_req.data[6:0];
                    if (host_req.data[7]) begin
                        s_next.cfg[CFG_CI_PULSE] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // Self-clearing pulse bits
        // A host rewrite of the reset pulse bit in the done cycle wins over self-clear
        if (rst_done && !(host_req.wr && s_reg.ptr == ADDR_CONFIG && host_req.data[CFG_RST_PULSE])) begin
            s_next.cfg[CFG_RST_PULSE] = 1'b0;
        end
        if (ci_done) begin
            s_next.cfg[CFG_CI_PULSE] = 1'b0;
        end
        // Initialise bit restores defaults but keeps pointer, pending flags and tree lock
        if (init) begin
            s_next.cfg      = CONFIG_RST;
            s_next.st1      = BYTE_ZERO;
            s_next.st2      = BYTE_ZERO;
            s_next.msk1     = BYTE_ZERO;
            s_next.msk2     = BYTE_ZERO;
            s_next.intr_low = INTR_LOW_RST;
        end
        // External low on the pin: every register to default
        if (pin_reset) begin
            s_next.cfg      = CONFIG_RST;
            s_next.st1      = BYTE_ZERO;
            s_next.st2      = BYTE_ZERO;
            s_next.pend1    = BYTE_ZERO;
            s_next.pend2    = BYTE_ZERO;
            s_next.msk1     = BYTE_ZERO;
            s_next.msk2     = BYTE_ZERO;
            s_next.intr_low = INTR_LOW_RST;
            s_next.ptr      = PTR_RST;
            s_next.dac_rst  = 1'b1;
        end
        // Pin drivers; open drain, only ever pulls low
        s_next.rst_oe_n = !rst_busy;
        s_next.ci_oe_n  = !ci_busy;
        if (rst_busy) begin
            s_next.blank = BLANK_CYC;
        end else if (s_reg.blank != BLANK_ZERO) begin
            s_next.blank = s_reg.blank - 3'h1;
        end
        // Interrupt pin tracks unmasked status, gated and held off
        st1_cur = s_next.st1 & ~s_next.msk1;
        st2_cur = s_next.st2 & ~{1'b1, s_next.msk2[6:0]};
        s_next.int_n = !(s_next.cfg[CFG_INT_EN] && !s_next.cfg[CFG_HOLD]
                         && (|{st1_cur, st2_cur}));
        s_next.monitor_run = s_next.cfg[CFG_START] && !s_next.cfg[CFG_HOLD];
        // Parity chain: all high gives high, each lowered pin toggles
        s_next.tree_out = ~(^(~tree_q));
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_reg             <= '0;
            s_reg.cfg         <= CONFIG_RST;
            s_reg.int_n       <= 1'b1;
            s_reg.rst_oe_n    <= 1'b1;
            s_reg.ci_oe_n     <= 1'b1;
            s_reg.tree_armed  <= 1'b1;
            s_reg.tree_out    <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    // Test mode latched only while armed; power reset alone re-arms
    logic tree_mode_reg;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tree_mode_reg <= 1'b0;
        end else begin
            tree_mode_reg <= s_next.tree_armed && (tree_req || tree_mode_reg);
        end
    end

    assign rd_data               = s_reg.rd_data;
    assign monitor_run           = s_reg.monitor_run;
    assign int_n                 = s_reg.int_n;
    assign reset_pin_out         = 1'b0;
    assign reset_pin_oe_n        = s_reg.rst_oe_n;
    assign intrusion_clear_bit   = s_reg.ci_oe_n;
    assign analog_data_reset     = s_reg.dac_rst;
    assign addr_sel_low_tree_out = s_reg.tree_out;
    assign tree_mode             = tree_mode_reg;

    // Helper: length of the current low drive
    logic [31:0] low_cnt;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            low_cnt <= '0;
        end else begin
            low_cnt <= s_reg.rst_oe_n ? 32'h0 : low_cnt + 32'h1;
        end
    end

    AST_READ_CLEARS: assert property (@(posedge core_clk) disable iff (rst)
        host_req.rd && s_reg.ptr == ADDR_STATUS1 && !merge && !pin_reset |=> s_reg.st1 == BYTE_ZERO)
        else $error("status 1 not cleared by read");
    AST_READ_DATA: assert property (@(posedge core_clk) disable iff (rst)
        host_req.rd && s_reg.ptr == ADDR_STATUS2 |=> rd_data == $past(s_reg.st2))
        else $error("read answer is not old status");
    AST_NO_EARLY_MERGE: assert property (@(posedge core_clk) disable iff (rst)
        ref_busy && !host_req.rd && !pin_reset && !(host_req.wr && host_req.data[CFG_INIT])
        |=> s_reg.st1 == $past(s_reg.st1))
        else $error("status changed inside refresh guard");
    AST_HOLD_INT: assert property (@(posedge core_clk) disable iff (rst)
        s_next.cfg[CFG_HOLD] |=> int_n)
        else $error("interrupt active while held");
    AST_HOLD_STOPS: assert property (@(posedge core_clk) disable iff (rst)
        s_next.cfg[CFG_HOLD] |=> !monitor_run)
        else $error("loop runs while held");
    AST_INT_GATE: assert property (@(posedge core_clk) disable iff (rst)
        !s_next.cfg[CFG_INT_EN] |=> int_n)
        else $error("interrupt active while disabled");
    AST_RST_ENABLE: assert property (@(posedge core_clk) disable iff (rst)
        !s_reg.msk2[MASK2_RST_EN] && !rst_busy |=> ##1 reset_pin_oe_n)
        else $error("reset pin driven while disabled");
    AST_PULSE_LEN: assert property (@(posedge core_clk) disable iff (rst)
        $rose(reset_pin_oe_n) |-> $past(low_cnt) >= 32'(PULSE_LEN - 1))
        else $error("reset pulse too short");
    AST_TREE_LOCK: assert property (@(posedge core_clk) disable iff (rst)
        host_req.wr && s_reg.ptr == ADDR_CONFIG |=> !tree_mode ##1 !tree_mode)
        else $error("test mode after config write");
    AST_SET_WINS: assert property (@(posedge core_clk) disable iff (rst)
        rd_st && !merge && !pin_reset && (|loop_events.st1)
        |=> (s_reg.pend1 & $past(loop_events.st1)) == $past(loop_events.st1))
        else $error("flag lost in clearing read");
endmodule : monitor_status_reset_control
`default_nettype wire

/* File: rtl/msrc_pkg.sv */
/*
 Shared constants and carrier types for the monitor status, reset pin and
 board-test control block. Assumes a 20 MHz core clock.
*/
package msrc_pkg;
    // Register addresses seen through the address pointer
    localparam logic [7:0] ADDR_CONFIG    = 8'h40;
    localparam logic [7:0] ADDR_STATUS1   = 8'h41;
    localparam logic [7:0] ADDR_STATUS2   = 8'h42;
    localparam logic [7:0] ADDR_MASK1     = 8'h43;
    localparam logic [7:0] ADDR_MASK2     = 8'h44;
    localparam logic [7:0] ADDR_INTRUSION = 8'h46;
    // Reset values
    localparam logic [7:0] CONFIG_RST     = 8'h08;
    localparam logic [7:0] BYTE_ZERO      = 8'h00;
    localparam logic [6:0] INTR_LOW_RST   = 7'h00;
    localparam logic [7:0] PTR_RST        = 8'h00;
    // Configuration and mask 2 bit positions
    localparam int CFG_START     = 0;
    localparam int CFG_INT_EN    = 1;
    localparam int CFG_HOLD      = 3;
    localparam int CFG_RST_PULSE = 4;
    localparam int CFG_CI_PULSE  = 6;
    localparam int CFG_INIT      = 7;
    localparam int MASK2_RST_EN  = 7;
    // Timing
    localparam int CLK_HZ       = 20_000_000;
    localparam int CYC_PER_MS   = CLK_HZ / 1000;
    localparam int PULSE_MS     = 20;
    localparam int REFRESH_MS   = 400;
    localparam int PULSE_CYC    = PULSE_MS * CYC_PER_MS;
    localparam int REFRESH_CYC  = REFRESH_MS * CYC_PER_MS;
    // Three stages, agreement and the driver flop must pass before the pin is trusted
    localparam logic [2:0] BLANK_CYC = 3'h6;
    localparam logic [2:0] BLANK_ZERO = 3'h0;

    // New flags from one step of the monitoring loop
    typedef struct packed {
        logic [7:0] st1;
        logic [7:0] st2;
    } events_t;

    // Requests from the serial-bus engine
    typedef struct packed {
        logic       ptr_wr;
        logic       wr;
        logic       rd;
        logic [7:0] data;
    } host_req_t;

    // State of the control block apart from timers, synchroniser and test-mode latch
    typedef struct packed {
        logic [7:0] cfg;
        logic [7:0] st1;
        logic [7:0] st2;
        logic [7:0] pend1;
        logic [7:0] pend2;
        logic [7:0] msk1;
        logic [7:0] msk2;
        logic [6:0] intr_low;
        logic [7:0] ptr;
        logic [7:0] rd_data;
        logic       int_n;
        logic       rst_oe_n;
        logic       ci_oe_n;
        logic [2:0] blank;
        logic       tree_armed;
        logic       tree_out;
        logic       dac_rst;
        logic       monitor_run;
    } state_t;
endpackage : msrc_pkg

/* File: rtl/pin_sync.sv */
/*
 Three-stage synchroniser for a group of pins; a bit changes only once the
 second and third stage agree. Assumes pins are asynchronous to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         core_clk, // Core clock
    input  wire logic         rst,      // Async reset, high
    input  wire logic [W-1:0] pin,      // Raw pins
    output logic      [W-1:0] q         // Filtered level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;

    // Stage chain; first stage feeds only the second
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            q_reg  <= RST_VAL;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int i = 0; i < W; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    q_reg[i] <= s3_reg[i];
                end
            end
        end
    end
    assign q = q_reg;
endmodule : pin_sync
`default_nettype wire

/* File: rtl/pulse_timer.sv */
/*
 One-shot timer: busy stays high exactly CYC cycles after start, then done
 pulses once. Assumes start is a same-clock level or pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
    parameter int CYC = 16
) (
    input  wire logic core_clk, // Core clock
    input  wire logic rst,      // Async reset, high
    input  wire logic clear,    // Abort, back to idle
    input  wire logic start,    // Start when idle
    output logic      busy,     // Interval running
    output logic      done      // One-cycle end pulse
);
    localparam int W = $clog2(CYC + 1);
    localparam logic [W-1:0] LOAD = W'(CYC - 1);
    localparam logic [W-1:0] CNT_ZERO = '0;
    logic [W-1:0] cnt_reg;
    logic         busy_reg;
    logic         done_reg;

    // Count down; length is exact, so no rounding below the minimum
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= CNT_ZERO;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (clear) begin
            cnt_reg  <= CNT_ZERO;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (!busy_reg && start) begin
                cnt_reg  <= LOAD;
                busy_reg <= 1'b1;
            end else if (busy_reg) begin
                if (cnt_reg == CNT_ZERO) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end
        end
    end
    assign busy = busy_reg;
    assign done = done_reg;
endmodule : pulse_timer
`default_nettype wire

/* File: test/board_model.sv */
/*
 Board side of the reset pin: a pull-up and one board device that may pull
 the line low. Assumes the block drives the pin through an active-low enable.
*/
`timescale 1ns/1ps
`default_nettype none
module board_model (
    input  wire logic oe_n,     // Block pulls low when 0
    input  wire logic pull_low, // Board device pulls low
    output logic      pin       // Resolved wire level
);
    // Open drain with pull-up, so any low party wins and idle reads high
    assign pin = (!oe_n || pull_low) ? 1'b0 : 1'b1;
endmodule : board_model
`default_nettype wire

/* File: test/tb.sv */
/*
 Self-checking bench for the status, reset pin and tree test block.
 Assumes short pulse and refresh counts so the run stays brief.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin error_cnt++; \
    $display("FAIL %s exp %h got %h", nm, ex, got); end end
module tb;
    import msrc_pkg::*;
    localparam int PL = 20;
    localparam int RL = 30;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    host_req_t   host_req = '0;
    events_t     loop_events = '0;
    logic        loop_pass_done = 1'b0;
    logic        pull_low = 1'b0;
    logic        analog_out_tree_in = 1'b1;
    logic [15:0] tree_pins = 16'hffff;
    logic [7:0]  rd_data, val, exp8, exp9;
    logic        reset_pin_in, reset_pin_out, reset_pin_oe_n, monitor_run, int_n;
    logic        intrusion_clear_bit, analog_data_reset, tree_out, tree_mode;
    int          error_cnt = 0;
    int          checks = 0;
    int          low_cnt = 0;
    int          ar_cnt = 0;
    int          ci_cnt = 0;
    int          base = 0;
    int          n;

    monitor_status_reset_control #(.TREE_N(16), .PULSE_LEN(PL), .REFRESH_LEN(RL)) dut (
        .core_clk(core_clk), .rst(rst), .host_req(host_req), .rd_data(rd_data),
        .loop_events(loop_events), .loop_pass_done(loop_pass_done), .monitor_run(monitor_run),
        .int_n(int_n), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
        .reset_pin_oe_n(reset_pin_oe_n), .intrusion_clear_bit(intrusion_clear_bit),
        .analog_data_reset(analog_data_reset), .analog_out_tree_in(analog_out_tree_in),
        .tree_pins(tree_pins), .addr_sel_low_tree_out(tree_out), .tree_mode(tree_mode));
    board_model board (.oe_n(reset_pin_oe_n), .pull_low(pull_low), .pin(reset_pin_in));

    always #25 core_clk = ~core_clk;

    // Pulse length and data-reset pulses counted beside the main sequence
    always @(posedge core_clk) begin
        low_cnt <= low_cnt + int'(reset_pin_oe_n === 1'b0);
        ar_cnt  <= ar_cnt + int'(analog_data_reset === 1'b1);
        ci_cnt  <= ci_cnt + int'(intrusion_clear_bit === 1'b0);
    end

    // All pins high gives high; every lowered pin flips the result
    function automatic logic tree_exp(input logic [15:0] p);
        return ($countones(~p) % 2) == 0;
    endfunction : tree_exp

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : cyc

    // Pointer load, then write; idle cycle keeps requests apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_req = '{1'b1, 1'b0, 1'b0, a};
        cyc(1);
        host_req = '{1'b0, 1'b1, 1'b0, d};
        cyc(1);
        host_req = '0;
        cyc(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        host_req = '{1'b1, 1'b0, 1'b0, a};
        cyc(1);
        host_req = '{1'b0, 1'b0, 1'b1, 8'h00};
        cyc(1);
        host_req = '0;
        cyc(1);
        q = rd_data;
    endtask : rd

    task automatic merge(input logic [7:0] f);
        loop_events.st1 = f;
        cyc(1);
        loop_events = '0;
        loop_pass_done = 1'b1;
        cyc(1);
        loop_pass_done = 1'b0;
        cyc(3);
    endtask : merge

    task automatic results();
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // Hang guard, well beyond the whole sequence
    initial begin
        #(50 * 5000);
        error_cnt++;
        results();
    end

    initial begin
        n = $urandom(62366);
        cyc(20);
        rst = 1'b0;
        cyc(8);
        // Tree test entered before any configuration write
        `CHK("tree_mode", 1'b1, tree_mode)
        `CHK("tree_high", 1'b1, tree_out)
        for (int i = 0; i < 6; i++) begin
            tree_pins = (i == 0) ? 16'hfffe : 16'($urandom);
            cyc(12);
            `CHK("tree_out", tree_exp(tree_pins), tree_out)
        end
        tree_pins = 16'hffff;
        analog_out_tree_in = 1'b0;
        wr(ADDR_CONFIG, 8'h03);
        analog_out_tree_in = 1'b1;
        cyc(8);
        `CHK("tree_again", 1'b0, tree_mode)
        `CHK("run", 1'b1, monitor_run)
        rd(ADDR_CONFIG, val);
        `CHK("cfg", 8'h03, val)
        rd(8'h55, val);
        `CHK("unmapped", 8'h00, val)
        // Flags merge, hold and enable gating of the interrupt
        exp8 = 8'($urandom) | 8'h01;
        merge(exp8);
        `CHK("int_set", 1'b0, int_n)
        wr(ADDR_CONFIG, 8'h0b);
        `CHK("int_hold", 1'b1, int_n)
        `CHK("run_hold", 1'b0, monitor_run)
        wr(ADDR_CONFIG, 8'h01);
        `CHK("int_off", 1'b1, int_n)
        wr(ADDR_CONFIG, 8'h03);
        `CHK("int_back", 1'b0, int_n)
        rd(ADDR_STATUS1, val);
        `CHK("status", exp8, val)
        `CHK("int_clr", 1'b1, int_n)
        rd(ADDR_STATUS1, val);
        `CHK("reread", 8'h00, val)
        merge(8'h80);
        `CHK("guard", 1'b1, int_n)
        cyc(RL);
        merge(8'h00);
        rd(ADDR_STATUS1, val);
        `CHK("after_guard", 8'h80, val)
        // Events standing through a clearing read must not be lost
        exp8 = 8'($urandom) | 8'h01;
        exp9 = 8'($urandom) | 8'h01;
        loop_events = '{exp8, exp9};
        rd(ADDR_STATUS2, val);
        loop_events = '0;
        `CHK("st2_read", 8'h00, val)
        cyc(RL);
        merge(8'h00);
        `CHK("int_again", 1'b0, int_n)
        rd(ADDR_STATUS1, val);
        `CHK("set_wins1", exp8, val)
        rd(ADDR_STATUS2, val);
        `CHK("set_wins2", exp9, val)
        // Reset pulse refused until the mask enables the pin function
        base = low_cnt;
        wr(ADDR_CONFIG, 8'h13);
        cyc(5);
        `CHK("no_pulse", 0, low_cnt - base)
        wr(ADDR_MASK2, 8'h80);
        cyc(PL + 10);
        `CHK("pulse_len", PL, low_cnt - base)
        `CHK("pin_data", 1'b0, reset_pin_out)
        `CHK("oe_idle", 1'b1, reset_pin_oe_n)
        rd(ADDR_CONFIG, val);
        `CHK("self_clr", 8'h03, val)
        // External low on the pin restores defaults
        base = ar_cnt;
        pull_low = 1'b1;
        cyc(10);
        pull_low = 1'b0;
        cyc(10);
        `CHK("dac_rst", 1, ar_cnt - base)
        rd(ADDR_CONFIG, val);
        `CHK("cfg_dflt", CONFIG_RST, val)
        rd(ADDR_MASK2, val);
        `CHK("mask2_dflt", BYTE_ZERO, val)
        // Mask now cleared, so a second external low is ignored
        wr(ADDR_CONFIG, 8'h03);
        pull_low = 1'b1;
        cyc(10);
        pull_low = 1'b0;
        cyc(10);
        rd(ADDR_CONFIG, val);
        `CHK("ext_ignored", 8'h03, val)
        // Intrusion line pulse timed like the reset pulse, then self-clears
        base = ci_cnt;
        wr(ADDR_INTRUSION, 8'h80);
        cyc(PL + 10);
        `CHK("ci_len", PL, ci_cnt - base)
        rd(ADDR_INTRUSION, val);
        `CHK("ci_clr", 8'h00, val)
        // Power reset re-arms the tree test
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(8);
        `CHK("tree_rearm", 1'b1, tree_mode)
        results();
    end
endmodule : tb
`default_nettype wire
